// ### logic/sbc_regs.sv
/*
  Service and boost converter control register bank, written by whole 16-bit words.
  Assumes the serial front end runs on mclk_i and pulses wr_valid_i once per word.
*/
`timescale 1ns/100ps

module sbc_regs
  import sbc_pkg::*;
#(
  parameter int unsigned TIMEOUT_MS  = WDOG_TIMEOUT_MS,
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_MS * MCLK_KHZ,
  parameter int unsigned CHANNELS    = 4
) (
  input  wire logic                mclk_i,
  input  wire logic                reset_i,
  input  wire logic                wr_valid_i,
  input  wire logic [15:0]         wr_data_i,
  input  wire logic                wdog_enable_i,
  output logic                     sw_reset_o,
  output logic                     user_toggle_o,
  output logic                     fault_alert_o,
  output logic                     keepalive_o,
  output logic                     boost_comp_select_o,
  output logic [1:0]               boost_phase_select_o,
  output logic [1:0]               boost_freq_select_o,
  output logic [1:0]               boost_vmax_select_o,
  output logic [15:0]              boost_ctrl_rd_o,
  output logic [CHANNELS-1:0]      boost_clk_o
);

  sbc_svc_word_type     svc_word;
  sbc_boost_type        boost_wr;
  sbc_boost_type        boost_q;
  sbc_boost_type        boost_d;

  logic                 is_svc;
  logic                 is_boost;
  logic                 svc_wr;
  logic                 boost_wr_en;
  logic                 reset_code;
  logic                 keep_code;
  logic                 soft_rst;
  logic                 any_rst;
  logic                 keep_wr;

  logic                 toggle_q;
  logic                 toggle_d;
  logic                 sw_reset_q;
  logic                 keep_q;

  logic [31:0]          wdog_cnt_q;
  logic [31:0]          wdog_cnt_d;
  logic                 wdog_expire;
  logic                 alert_q;
  logic                 alert_d;
  logic                 wdog_hit;

  logic [DIV_W-1:0]     period;
  logic [DIV_W-1:0]     period_q;
  logic [DIV_W-1:0]     period_cnt_q;
  logic [DIV_W-1:0]     period_cnt_d;
  logic                 period_change;
  logic [DIV_W-1:0]     half_ofs;
  logic [DIV_W-1:0]     quarter_ofs;
  logic [DIV_W-1:0]     three_q_ofs;
  logic [DIV_W-1:0]     offset [CHANNELS];

  logic [15:0]          rd_word_q;
  logic [15:0]          rd_word_d;

  localparam int unsigned CNT_W = 32;

  // Word decode
  assign svc_word    = sbc_svc_word_type'(wr_data_i);
  assign is_svc      = (wr_data_i[15:13] == SEL_SERVICE);
  assign is_boost    = (wr_data_i[15:13] == SEL_BOOST);
  assign svc_wr      = wr_valid_i & is_svc;
  assign boost_wr_en = wr_valid_i & is_boost;

  // Boost fields, D12..D7 dropped
  assign boost_wr.comp  = wr_data_i[BST_COMP_POS];
  assign boost_wr.phase = wr_data_i[BST_PHASE_LSB +: 2];
  assign boost_wr.freq  = wr_data_i[BST_FREQ_LSB +: 2];
  assign boost_wr.vmax  = wr_data_i[BST_VMAX_LSB +: 2];

  // Service codes
  assign reset_code = (svc_word.code == SVC_RESET_CODE);
  assign keep_code  = (svc_word.code == SVC_KEEP_CODE);
  assign soft_rst   = svc_wr & reset_code;
  assign any_rst    = reset_i | soft_rst;
  assign keep_wr    = svc_wr & keep_code;

  // Toggle mirror
  assign toggle_d = svc_wr ? svc_word.toggle : toggle_q;

  always_ff @(posedge mclk_i) begin
    if (any_rst) begin
      toggle_q <= TOGGLE_RESET;
    end else begin
      toggle_q <= toggle_d;
    end
  end

  // Device reset pulse, one cycle after the code
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sw_reset_q <= 1'b0;
    end else begin
      sw_reset_q <= soft_rst;
    end
  end

  // Keep-alive pulse
  always_ff @(posedge mclk_i) begin
    if (any_rst) begin
      keep_q <= 1'b0;
    end else begin
      keep_q <= keep_wr;
    end
  end

  // Watchdog counter, held clear while disabled
  assign wdog_expire = wdog_enable_i & (wdog_cnt_q >= CNT_W'(TIMEOUT_CYC - 1));

  always_comb begin
    wdog_cnt_d = wdog_cnt_q;
    if (!wdog_enable_i || keep_wr) begin
      wdog_cnt_d = '0;
    end else if (!wdog_expire) begin
      wdog_cnt_d = wdog_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (any_rst) begin
      wdog_cnt_q <= '0;
    end else begin
      wdog_cnt_q <= wdog_cnt_d;
    end
  end

  // Alert: first expiry wins over a keep-alive in the same cycle
  assign wdog_hit = wdog_expire & ~alert_q;

  always_comb begin
    alert_d = alert_q;
    if (wdog_hit) begin
      alert_d = 1'b1;
    end else if (keep_wr) begin
      alert_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (any_rst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= alert_d;
    end
  end

  // Boost control register
  assign boost_d = boost_wr_en ? boost_wr : boost_q;

  always_ff @(posedge mclk_i) begin
    if (any_rst) begin
      boost_q <= BOOST_RESET;
    end else begin
      boost_q <= boost_d;
    end
  end

  // Readback image of the boost register
  assign rd_word_d = {SEL_BOOST, 6'h00, boost_d};

  always_ff @(posedge mclk_i) begin
    if (any_rst) begin
      rd_word_q <= {SEL_BOOST, 6'h00, BOOST_RESET};
    end else begin
      rd_word_q <= rd_word_d;
    end
  end

  // Switching period from the frequency field
  always_comb begin
    case (boost_q.freq)
      FREQ_250: period = DIV_W'(DIV_250);
      FREQ_410: period = DIV_W'(DIV_410);
      FREQ_650: period = DIV_W'(DIV_650);
      default:  period = DIV_W'(DIV_410);
    endcase
  end

  assign period_change = (period != period_q);

  // Shared period counter, restarted when the period changes
  always_comb begin
    period_cnt_d = period_cnt_q + 8'h01;
    if (period_change || (period_cnt_q >= period - 8'h01)) begin
      period_cnt_d = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      period_q     <= DIV_W'(DIV_410);
      period_cnt_q <= '0;
    end else begin
      period_q     <= period;
      period_cnt_q <= period_cnt_d;
    end
  end

  // Per-channel phase offsets
  assign half_ofs    = period >> 1;
  assign quarter_ofs = period >> 2;
  assign three_q_ofs = half_ofs + quarter_ofs;

  always_comb begin
    offset[0] = '0;
    offset[1] = '0;
    offset[2] = '0;
    offset[3] = '0;
    case (boost_q.phase)
      PHASE_ALIGNED: begin
        offset[1] = '0;
        offset[2] = '0;
        offset[3] = '0;
      end
      PHASE_AB_CD: begin
        offset[2] = half_ofs;
        offset[3] = half_ofs;
      end
      PHASE_AC_BD: begin
        offset[1] = half_ofs;
        offset[3] = half_ofs;
      end
      PHASE_QUAD: begin
        offset[1] = quarter_ofs;
        offset[2] = half_ofs;
        offset[3] = three_q_ofs;
      end
      default: begin
        offset[1] = '0;
      end
    endcase
  end

  // One clock generator per channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    sbc_phase_gen #(
      .W(DIV_W)
    ) u_gen (
      .mclk_i   (mclk_i),
      .reset_i  (reset_i),
      .count_i  (period_cnt_q),
      .period_i (period),
      .offset_i (offset[ch % 4]),
      .clk_o    (boost_clk_o[ch])
    );
  end

  // Outputs
  assign sw_reset_o           = sw_reset_q;
  assign user_toggle_o        = toggle_q;
  assign fault_alert_o        = alert_q;
  assign keepalive_o          = keep_q;
  assign boost_comp_select_o  = boost_q.comp;
  assign boost_phase_select_o = boost_q.phase;
  assign boost_freq_select_o  = boost_q.freq;
  assign boost_vmax_select_o  = boost_q.vmax;
  assign boost_ctrl_rd_o      = rd_word_q;

endmodule

// ### logic/sbc_pkg.sv
/*
  Constants and carrier types for the service and boost control register bank.
  Assumes one 25 MHz clock and a serial front end that hands over whole 16-bit words.
*/
package sbc_pkg;

  // Clock rate
  localparam int unsigned MCLK_KHZ        = 25000;

  // Register select codes in D15..D13
  localparam logic [2:0]  SEL_SERVICE     = 3'h4;
  localparam logic [2:0]  SEL_BOOST       = 3'h3;

  // Service register field positions and codes
  localparam int unsigned SVC_TOGGLE_POS  = 12;
  localparam int unsigned SVC_CODE_MSB    = 11;
  localparam logic [11:0] SVC_RESET_CODE  = 12'h555;
  localparam logic [11:0] SVC_KEEP_CODE   = 12'h195;

  // Status register position of the toggle mirror
  localparam int unsigned STAT_TOGGLE_POS = 11;

  // Boost control field positions
  localparam int unsigned BST_COMP_POS    = 6;
  localparam int unsigned BST_PHASE_LSB   = 4;
  localparam int unsigned BST_FREQ_LSB    = 2;
  localparam int unsigned BST_VMAX_LSB    = 0;

  // Phase modes
  localparam logic [1:0]  PHASE_ALIGNED   = 2'h0;
  localparam logic [1:0]  PHASE_AB_CD     = 2'h1;
  localparam logic [1:0]  PHASE_AC_BD     = 2'h2;
  localparam logic [1:0]  PHASE_QUAD      = 2'h3;

  // Frequency selects and their targets
  localparam logic [1:0]  FREQ_250        = 2'h0;
  localparam logic [1:0]  FREQ_410        = 2'h1;
  localparam logic [1:0]  FREQ_650        = 2'h2;
  localparam int unsigned FREQ_250_KHZ    = 250;
  localparam int unsigned FREQ_410_KHZ    = 410;
  localparam int unsigned FREQ_650_KHZ    = 650;
  localparam int unsigned DIV_250         = MCLK_KHZ / FREQ_250_KHZ;
  localparam int unsigned DIV_410         = MCLK_KHZ / FREQ_410_KHZ;
  localparam int unsigned DIV_650         = MCLK_KHZ / FREQ_650_KHZ;
  localparam int unsigned DIV_W           = 8;

  // Maximum boost voltage selects
  localparam logic [1:0]  VMAX_23V        = 2'h0;
  localparam logic [1:0]  VMAX_24V5       = 2'h1;
  localparam logic [1:0]  VMAX_27V        = 2'h2;
  localparam logic [1:0]  VMAX_29V5       = 2'h3;

  // Reset values
  localparam logic        COMP_RESET      = 1'b0;
  localparam logic [1:0]  PHASE_RESET     = PHASE_ALIGNED;
  localparam logic [1:0]  FREQ_RESET      = FREQ_410;
  localparam logic [1:0]  VMAX_RESET      = VMAX_23V;
  localparam logic        TOGGLE_RESET    = 1'b0;

  // Watchdog timeout
  localparam int unsigned WDOG_TIMEOUT_MS = 5;

  typedef struct packed {
    logic [2:0]  sel;
    logic        toggle;
    logic [11:0] code;
  } sbc_svc_word_type;

  typedef struct packed {
    logic        comp;
    logic [1:0]  phase;
    logic [1:0]  freq;
    logic [1:0]  vmax;
  } sbc_boost_type;

  localparam sbc_boost_type BOOST_RESET = '{comp: COMP_RESET, phase: PHASE_RESET,
                                           freq: FREQ_RESET, vmax: VMAX_RESET};

endpackage

// ### logic/sbc_phase_gen.sv
/*
  One boost converter switching clock, phase shifted from a shared period counter.
  Assumes count, period and offset all come from the same clock domain.
*/
`timescale 1ns/100ps
module sbc_phase_gen
  import sbc_pkg::*;
#(
  parameter int unsigned W = DIV_W
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] count_i,
  input  wire logic [W-1:0] period_i,
  input  wire logic [W-1:0] offset_i,
  output logic              clk_o
);

  logic [W:0]   pos_raw;
  logic [W-1:0] pos;
  logic [W-1:0] half;
  logic         clk_q;
  logic         clk_d;

  // Wrap count plus offset into one period
  assign pos_raw = {1'b0, count_i} + {1'b0, offset_i};
  assign pos     = (pos_raw >= {1'b0, period_i}) ? W'(pos_raw - {1'b0, period_i}) : pos_raw[W-1:0];
  assign half    = period_i >> 1;
  assign clk_d   = (pos < half);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= clk_d;
    end
  end

  assign clk_o = clk_q;

endmodule

// ### tb/sbc_regs_checker.sv
/*
  Port checker for sbc_regs, bound into every instance.
  Assumes one clock and that the bench idles 210 cycles after a write.
*/
`timescale 1ns/100ps
module sbc_regs_checker
  import sbc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = 20,
  parameter int unsigned CHANNELS    = 4
) (
  input  wire logic                mclk_i,
  input  wire logic                reset_i,
  input  wire logic                wr_valid_i,
  input  wire logic [15:0]         wr_data_i,
  input  wire logic                wdog_enable_i,
  input  wire logic                sw_reset_o,
  input  wire logic                user_toggle_o,
  input  wire logic                fault_alert_o,
  input  wire logic                keepalive_o,
  input  wire logic                boost_comp_select_o,
  input  wire logic [1:0]          boost_phase_select_o,
  input  wire logic [1:0]          boost_freq_select_o,
  input  wire logic [1:0]          boost_vmax_select_o,
  input  wire logic [15:0]         boost_ctrl_rd_o,
  input  wire logic [CHANNELS-1:0] boost_clk_o
);
  logic [7:0]      still_q;
  int unsigned     quiet_q;
  wire logic [3:0] ck   = boost_clk_o[3:0];
  wire logic [2:0] sel  = wr_data_i[15:13];
  wire logic       svc  = wr_valid_i && sel == SEL_SERVICE;
  wire logic       kick = svc && wr_data_i[11:0] == SVC_KEEP_CODE;
  wire logic       wipe = svc && wr_data_i[11:0] == SVC_RESET_CODE;
  wire logic       ph_ok = boost_phase_select_o == PHASE_ALIGNED ? (ck == 4'h0 || ck == 4'hf) :
                           boost_phase_select_o == PHASE_AB_CD ? (ck[0] == ck[1] && ck[2] == ck[3] && ck[0] != ck[2]) :
                           boost_phase_select_o == PHASE_AC_BD ? (ck[0] == ck[2] && ck[1] == ck[3] && ck[0] != ck[1]) :
                           (ck[0] != ck[2] && ck[1] != ck[3]);

  // Cycles since last write, cycles without keep-alive
  always_ff @(posedge mclk_i) begin
    still_q <= (reset_i || wr_valid_i) ? 8'h00 : still_q + {7'h00, still_q != 8'hff};
    quiet_q <= (reset_i || kick || wipe || !wdog_enable_i) ? 0 : quiet_q + 1;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_boost_write: assert property (wr_valid_i && sel == SEL_BOOST |=>
    boost_ctrl_rd_o == {3'h3, 6'h00, $past(wr_data_i[6:0])}) else $error("boost image wrong");
  a_rd_fields: assert property (boost_ctrl_rd_o == {3'h3, 6'h00, boost_comp_select_o,
    boost_phase_select_o, boost_freq_select_o, boost_vmax_select_o}) else $error("fields differ");
  a_ignore_other: assert property (wr_valid_i && sel != SEL_SERVICE && sel != SEL_BOOST |=>
    $stable(boost_ctrl_rd_o) && $stable(user_toggle_o)) else $error("other select acted");
  a_toggle_mirror: assert property (svc && !wipe |=>
    user_toggle_o == $past(wr_data_i[SVC_TOGGLE_POS])) else $error("toggle wrong");
  a_soft_reset: assert property (wipe |=> sw_reset_o && !user_toggle_o &&
    boost_ctrl_rd_o == 16'h6004) else $error("soft reset missing");
  a_reset_pulse: assert property (sw_reset_o |-> $past(wipe)) else $error("stray reset pulse");
  a_keep_pulse: assert property (keepalive_o == $past(kick)) else $error("keep pulse wrong");
  a_alert_late: assert property (quiet_q > TIMEOUT_CYC |-> fault_alert_o) else $error("alert late");
  a_alert_early: assert property ($rose(fault_alert_o) |-> quiet_q + 1 >= TIMEOUT_CYC)
    else $error("alert early");
  a_alert_hold: assert property (fault_alert_o && !kick && !wipe |=> fault_alert_o)
    else $error("alert dropped");
  a_quad_order: assert property (still_q > 8'd209 && boost_phase_select_o == PHASE_QUAD && $rose(ck[1]) |->
    ck == 4'h6) else $error("quad order wrong");
  a_phase_rel: assert property (still_q > 8'd209 |-> ph_ok) else $error("phase relation wrong");

  c_wipe: cover property (wipe);
  c_alert: cover property ($rose(fault_alert_o));
  c_quad: cover property (still_q > 8'd209 && boost_phase_select_o == PHASE_QUAD);
endmodule

bind sbc_regs sbc_regs_checker #(.TIMEOUT_CYC(TIMEOUT_CYC), .CHANNELS(CHANNELS)) u_chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
  .wdog_enable_i(wdog_enable_i), .sw_reset_o(sw_reset_o), .user_toggle_o(user_toggle_o),
  .fault_alert_o(fault_alert_o), .keepalive_o(keepalive_o), .boost_comp_select_o(boost_comp_select_o),
  .boost_phase_select_o(boost_phase_select_o), .boost_freq_select_o(boost_freq_select_o),
  .boost_vmax_select_o(boost_vmax_select_o), .boost_ctrl_rd_o(boost_ctrl_rd_o), .boost_clk_o(boost_clk_o));

// ### tb/sbc_mcu_model.sv
/*
  Controller model that hands whole write words to the register bank.
  Assumes words change at the falling edge of mclk_i.
*/
`timescale 1ns/100ps
module sbc_mcu_model (
  input  wire logic   mclk_i,
  output logic        wr_valid_o,
  output logic [15:0] wr_data_o
);
  initial begin
    wr_valid_o = 1'b0;
    wr_data_o  = 16'h0000;
  end

  // One word per pulse, inverted data when idle
  task automatic send(input logic [15:0] w);
    @(negedge mclk_i);
    wr_valid_o <= 1'b1;
    wr_data_o  <= w;
    @(negedge mclk_i);
    wr_valid_o <= 1'b0;
    wr_data_o  <= ~w;
  endtask
endmodule

// ### tb/test_sbc_regs.sv
/*
  Self-checking bench for sbc_regs with a controller model.
  Assumes a 25 MHz clock and a shortened watchdog timeout.
*/
`timescale 1ns/100ps
module test_sbc_regs
  import sbc_pkg::*;
;
  localparam int TO = 20;
  logic        mclk_i = 1'b0, reset_i = 1'b1, wdog_enable_i = 1'b0, wv;
  logic        sw_reset_o, user_toggle_o, fault_alert_o, keepalive_o, boost_comp_select_o;
  logic [1:0]  boost_phase_select_o, boost_freq_select_o, boost_vmax_select_o;
  logic [15:0] wd, boost_ctrl_rd_o, brd = 16'h6004, w;
  logic [3:0]  boost_clk_o;
  logic [18:0] notes[$];
  logic        tgl = 1'b0;
  int          err_total = 0, checks = 0, seed = 63;
  time         t_last = 0, t_per = 0;

  always #20 mclk_i = ~mclk_i;

  sbc_regs #(.TIMEOUT_CYC(TO)) dut (.mclk_i(mclk_i), .reset_i(reset_i), .wr_valid_i(wv), .wr_data_i(wd),
    .wdog_enable_i(wdog_enable_i), .sw_reset_o(sw_reset_o), .user_toggle_o(user_toggle_o),
    .fault_alert_o(fault_alert_o), .keepalive_o(keepalive_o), .boost_comp_select_o(boost_comp_select_o),
    .boost_phase_select_o(boost_phase_select_o), .boost_freq_select_o(boost_freq_select_o),
    .boost_vmax_select_o(boost_vmax_select_o), .boost_ctrl_rd_o(boost_ctrl_rd_o), .boost_clk_o(boost_clk_o));
  sbc_mcu_model mcu (.mclk_i(mclk_i), .wr_valid_o(wv), .wr_data_o(wd));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] x);
    logic sr, ka;
    sr = 1'b0;
    ka = 1'b0;
    if (x[15:13] == SEL_SERVICE && x[11:0] == SVC_RESET_CODE) begin
      sr = 1'b1;
      tgl = 1'b0;
      brd = 16'h6004;
    end else if (x[15:13] == SEL_SERVICE) begin
      tgl = x[12];
      ka = x[11:0] == SVC_KEEP_CODE;
    end else if (x[15:13] == SEL_BOOST) begin
      brd = {3'h3, 6'h00, x[6:0]};
    end
    notes.push_back({sr, ka, tgl, brd});
    mcu.send(x);
  endtask

  // Compare each write's outcome with the oldest note
  always @(posedge mclk_i) begin
    if (wv === 1'b1) begin
      #1;
      chk(32'({sw_reset_o, keepalive_o, user_toggle_o, boost_ctrl_rd_o}), 32'(notes.pop_front()));
    end
  end

  always @(posedge boost_clk_o[0]) begin
    t_per = $time - t_last;
    t_last = $time;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    report_and_stop;
  end

  initial begin
    repeat (2) @(negedge mclk_i);
    reset_i = 1'b0;
    @(negedge mclk_i);
    chk(32'(boost_ctrl_rd_o), 32'h6004);
    chk(32'({user_toggle_o, fault_alert_o}), 32'h0);
    wr(16'h9000);
    wr(16'h8000);
    wr(16'h9abc);
    $display("toggle test done");
    repeat (6) begin
      w = $random(seed);
      wr({3'h3, w[12:0]});
      w = $random(seed);
      if (w[15:13] == SEL_SERVICE || w[15:13] == SEL_BOOST) w[15] = ~w[15];
      wr(w);
    end
    wr(16'h8555);
    $display("write test done");
    for (int p = 0; p < 4; p++) begin
      wr({3'h3, 6'h00, 1'b1, 2'(p), FREQ_410, VMAX_29V5});
      repeat (230) @(negedge mclk_i);
    end
    for (int f = 0; f < 4; f++) begin
      wr({3'h3, 6'h00, 1'b0, PHASE_QUAD, 2'(f), 2'(f)});
      repeat (250) @(negedge mclk_i);
      chk(32'(t_per / 40), f == 0 ? DIV_250 : f == 2 ? DIV_650 : DIV_410);
    end
    $display("boost clock test done");
    chk(32'(fault_alert_o), 32'h0);
    wdog_enable_i = 1'b1;
    repeat (TO + 3) @(negedge mclk_i);
    chk(32'(fault_alert_o), 32'h1);
    wr(16'h9195);
    chk(32'(fault_alert_o), 32'h0);
    repeat (3) begin
      repeat (TO - 5) @(negedge mclk_i);
      wr(16'h8195);
    end
    chk(32'(fault_alert_o), 32'h0);
    wdog_enable_i = 1'b0;
    $display("watchdog test done");
    wr(16'h9000);
    reset_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    reset_i = 1'b0;
    tgl = 1'b0;
    brd = 16'h6004;
    @(negedge mclk_i);
    chk(32'({user_toggle_o, boost_ctrl_rd_o}), 32'h6004);
    $display("second reset test done");
    report_and_stop;
  end
endmodule
